// ### core/input_alarm_status.sv
// Behaviour
// R1 - One fail bit per data line, 15:0
// R2 - Fail bits meaningful only with checker enabled
// R3 - Fail bits: no reset, write clears
// R4 - Zero-check alarm when write pointer all zeros
// R5 - Host resynchronises FIFO after zero-check alarm
// R6 - FIFO distance code in bits 13:11
// R7 - Host resyncs and clears after collision shutdown
// R8 - Bit 10 on converter clock stopped
// R9 - Host restores converter clock, clears bit
// R10 - Bit 9 on data clock stopped
// R11 - Host restores data clock, clears bit
// R12 - Output-gone follows clock-lost or collision alarms
// R13 - Output-gone drives mid-scale to every channel
// R14 - Host fixes faults, clears output-gone alarms
// R15 - Bit 7 on pattern mismatch
// R16 - Host honours only pattern alarm in checker mode
// R17 - Bit 5 on PLL lock loss
// R18 - Bit 4 on rising-edge parity error
// R19 - Bit 3 on falling-edge parity error
// R20 - Bit 2 on frame parity error
// R21 - Status has no reset, write clears
// R22 - Mask bit 1 suppresses alarm
// R23 - Shutdown needs enable and unmasked alarms
// R24 - Alarm bits sticky until software clears
`include "alarm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module input_alarm_status #(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire alarm_pkg::word_t reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Configuration
    input wire logic pattern_check_ena_i,
    input wire logic convclk_gone_ena_i,
    input wire logic dataclk_gone_ena_i,
    input wire logic collision_gone_ena_i,
    // Event sources
    input wire alarm_pkg::word_t pattern_line_fail_i,
    input wire logic pattern_mismatch_i,
    input wire alarm_pkg::wptr_t fifo_wptr_i,
    input wire logic [2:0] fifo_distance_i,
    input wire logic convclk_stopped_i,
    input wire logic dataclk_stopped_i,
    input wire logic pll_unlock_i,
    input wire logic rparity_err_i,
    input wire logic fparity_err_i,
    input wire logic frame_parity_err_i,
    // Channel data
    input wire logic [16*CHANNELS-1:0] chan_data_i,
    output logic [16*CHANNELS-1:0] chan_data_o,
    output logic output_shutdown_o
);
    import alarm_pkg::*;

    word_t fail_q;
    word_t status_q;
    word_t mask_q;
    logic [15:0] rdata_q;
    logic shut_q;
    logic [16*CHANNELS-1:0] data_q;

    wire wr_fail = reg_wr_i && (reg_addr_i == `ADDR_PATTERN_BIT_FAIL);
    wire wr_status = reg_wr_i && (reg_addr_i == `ADDR_ALARM_STATUS);
    wire wr_mask = reg_wr_i && (reg_addr_i == `ADDR_ALARM_MASK);

    // Raw events at their status positions; output-gone follows its sources
    wire ev_zero = (fifo_wptr_i == 8'h00); // R4
    wire ev_coll = fifo_distance_i[2]; // R6
    wire ev_one = !fifo_distance_i[2] && fifo_distance_i[1]; // R6
    wire ev_two = (fifo_distance_i == 3'b001); // R6
    wire ev_gone = convclk_stopped_i || dataclk_stopped_i || ev_coll; // R12
    word_t raw;
    assign raw = {ev_zero, 1'b0, ev_coll, ev_one, ev_two, convclk_stopped_i, // R8 R10
                  dataclk_stopped_i, ev_gone, pattern_mismatch_i, 1'b0, // R15
                  pll_unlock_i, rparity_err_i, fparity_err_i, // R17 R18 R19
                  frame_parity_err_i, 2'b00}; // R20

    // Write-one clears; a simultaneous event wins over the clear
    word_t status_d;
    assign status_d = ((status_q & ~(wr_status ? reg_wdata_i : 16'h0000)) | raw)
                      & `STATUS_USED; // R24 R21
    word_t fail_d;
    assign fail_d = (fail_q & ~(wr_fail ? reg_wdata_i : 16'h0000))
                    | (pattern_check_ena_i ? pattern_line_fail_i : 16'h0000); // R1 R2

    word_t act;
    assign act = status_q & ~mask_q; // R22
    wire shut_d = act[`BIT_OUTPUT_GONE] && (
        (convclk_gone_ena_i && act[`BIT_CONVCLK_GONE]) ||
        (dataclk_gone_ena_i && act[`BIT_DATACLK_GONE]) ||
        (collision_gone_ena_i && act[`BIT_COLL])); // R23

    wire [15:0] rdata_d = (reg_addr_i == `ADDR_PATTERN_BIT_FAIL) ? fail_q :
                          (reg_addr_i == `ADDR_ALARM_STATUS) ? status_q :
                          (reg_addr_i == `ADDR_ALARM_MASK) ? mask_q : 16'h0000;

    // No reset on the capture registers: contents depend on power-up
    always_ff @(posedge clk_i) begin
        fail_q <= fail_d; // R3
        status_q <= status_d; // R21
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_q <= `MASK_RESET;
            rdata_q <= 16'h0000;
            shut_q <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_q <= reg_wdata_i;
            end
            if (reg_rd_i) begin
                rdata_q <= rdata_d;
            end
            shut_q <= shut_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    data_q[16*g +: 16] <= `MID_SCALE;
                end else begin
                    data_q[16*g +: 16] <= shut_d ? `MID_SCALE : chan_data_i[16*g +: 16]; // R13
                end
            end
        end
    endgenerate

    assign reg_rdata_o = rdata_q;
    assign chan_data_o = data_q;
    assign output_shutdown_o = shut_q;

    AST_GONE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        convclk_stopped_i |=> status_q[`BIT_OUTPUT_GONE]) else $error("output gone not set");
    AST_CONVCLK: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        convclk_stopped_i |=> status_q[`BIT_CONVCLK_GONE]) else $error("convclk alarm missing");
    AST_DATACLK: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        dataclk_stopped_i |=> status_q[`BIT_DATACLK_GONE]) else $error("dataclk alarm missing");
    AST_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        (fifo_wptr_i == 8'h00) |=> status_q[`BIT_ZEROCHK]) else $error("zero check missing");
    AST_COLL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
        fifo_distance_i[2] |=> status_q[`BIT_COLL]) else $error("collision missing");
    AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R24
        status_q[`BIT_PLL] && !wr_status |=> status_q[`BIT_PLL]) else $error("alarm not sticky");
    AST_PLL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
        pll_unlock_i |=> status_q[`BIT_PLL]) else $error("pll alarm missing");
    AST_MIDSCALE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        shut_d |=> chan_data_o[15:0] == `MID_SCALE) else $error("no mid scale");
    AST_MASKED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R23
        mask_q[`BIT_OUTPUT_GONE] |=> !output_shutdown_o) else $error("masked shutdown");
    AST_FAIL_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        wr_fail && reg_wdata_i == 16'hFFFF && !pattern_check_ena_i |=> fail_q == 16'h0000)
        else $error("fail bits not cleared");

    COV_SHUT: cover property (@(posedge clk_i) disable iff (!rst_n_i) output_shutdown_o);
    COV_CLEAR: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_status ##1 status_q == 16'h0000);
    COV_PATTERN: cover property (@(posedge clk_i) disable iff (!rst_n_i) status_q[`BIT_PATTERN]);
endmodule : input_alarm_status
`default_nettype wire

// ### inc/alarm_consts.svh
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH
`define ADDR_PATTERN_BIT_FAIL 7'h04
`define ADDR_ALARM_STATUS 7'h05
`define ADDR_ALARM_MASK 7'h07
`define MASK_RESET 16'hFFFF
`define BIT_ZEROCHK 15
`define BIT_FIFO_HI 13
`define BIT_FIFO_LO 11
`define BIT_COLL 13
`define BIT_ONE_AWAY 12
`define BIT_TWO_AWAY 11
`define BIT_CONVCLK_GONE 10
`define BIT_DATACLK_GONE 9
`define BIT_OUTPUT_GONE 8
`define BIT_PATTERN 7
`define BIT_PLL 5
`define BIT_RPARITY 4
`define BIT_FPARITY 3
`define BIT_FRAME_PARITY 2
`define STATUS_USED 16'hBFBC
`define MID_SCALE 16'h8000
`endif

// ### inc/alarm_pkg.sv
package alarm_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0] wptr_t;
endpackage : alarm_pkg

// ### sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock and read data
    input wire logic clk_i,
    input wire logic [15:0] reg_rdata_i,
    // Register requests
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [6:0] reg_addr_o,
    output logic [15:0] reg_wdata_o
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
        @(negedge clk_i);
        // Released data is scrambled so nothing relies on it
        {reg_wr_o, reg_wdata_o} = {1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(negedge clk_i);
        {reg_rd_o, reg_addr_o} = {1'b1, a};
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask : rd
    // Clears every alarm once the fault source is gone
    task automatic recover();
        wr(7'h05, 16'hFFFF);
    endtask : recover
endmodule : host_model
`default_nettype wire

// ### sim/tb_input_alarm_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_input_alarm_status;
    import alarm_pkg::*;
    localparam logic [10:0] EVT [11] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040,
        11'h080, 11'h100, 11'h200, 11'h400};
    localparam logic [15:0] EXP [11] = '{16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0300, 16'h0500,
        16'h0080, 16'h0800, 16'h1000, 16'h2100, 16'h8000};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr, rd, ena;
    logic [6:0] addr;
    word_t wdata, rdata, fail, st;
    logic [10:0] ev = '0;
    logic [63:0] din = 64'h0123456789ABCDEF;
    logic [63:0] dout;
    logic sd;
    logic gena = 1'b1;
    int n_errors = 0;
    int cmp_count = 0;
    initial forever #4 clk_i = ~clk_i;
    input_alarm_status input_alarm_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pattern_check_ena_i(ena),
        .convclk_gone_ena_i(gena), .dataclk_gone_ena_i(gena), .collision_gone_ena_i(gena),
        .pattern_line_fail_i(fail), .pattern_mismatch_i(ev[6]), .fifo_wptr_i(ev[10] ? 8'h00 : 8'h01),
        .fifo_distance_i(ev[9:7]), .convclk_stopped_i(ev[5]), .dataclk_stopped_i(ev[4]), .pll_unlock_i(ev[3]),
        .rparity_err_i(ev[2]), .fparity_err_i(ev[1]), .frame_parity_err_i(ev[0]), .chan_data_i(din),
        .chan_data_o(dout), .output_shutdown_o(sd));
    host_model host_model_i (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic pulse(input logic [10:0] e);
        @(negedge clk_i);
        ev = e;
        @(negedge clk_i);
        ev = '0;
    endtask : pulse
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        {ena, fail} = '0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk("shutdown", sd, 1'b0);
        chk("chan reset", dout, {4{16'h8000}});
        host_model_i.rd(7'h07, st);
        chk("mask reset", st, 16'hFFFF);
        host_model_i.recover();
        host_model_i.wr(7'h04, 16'hFFFF);
        host_model_i.rd(7'h05, st);
        chk("status clear", st, 16'h0000);
        for (int i = 0; i < 11; i++) begin
            pulse(EVT[i]);
            repeat (3) @(negedge clk_i);
            host_model_i.rd(7'h05, st);
            chk("status event", st, EXP[i]);
            chk("masked shutdown", sd, 1'b0);
            chk("data pass", dout, din);
            host_model_i.recover();
            host_model_i.rd(7'h05, st);
            chk("status cleared", st, 16'h0000);
        end
        host_model_i.wr(7'h07, 16'h0000);
        pulse(11'h020);
        repeat (2) @(negedge clk_i);
        chk("shutdown", sd, 1'b1);
        chk("mid scale", dout, {4{16'h8000}});
        host_model_i.recover();
        repeat (2) @(negedge clk_i);
        chk("resume", dout, din);
        gena = 1'b0;
        pulse(11'h020);
        repeat (2) @(negedge clk_i);
        chk("no enable", sd, 1'b0);
        chk("no enable data", dout, din);
        host_model_i.recover();
        gena = 1'b1;
        ena = 1'b1;
        fail = 16'hA55A;
        pulse(11'h040);
        fail = '0;
        host_model_i.rd(7'h04, st);
        chk("line fail", st, 16'hA55A);
        host_model_i.rd(7'h05, st);
        chk("pattern alarm", st[7], 1'b1);
        host_model_i.wr(7'h04, 16'hA000);
        host_model_i.rd(7'h04, st);
        chk("fail clear", st, 16'h055A);
        host_model_i.rd(7'h06, st);
        chk("unmapped", st, 16'h0000);
        stop_test();
    end
endmodule : tb_input_alarm_status
`default_nettype wire
